// ### include/tpg_consts.svh
// named offsets, field positions, reset values and counts of the timer/pulse generator
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH
`define TPG_MODE_ADDR      12'hF90
`define TPG_MODULO_HIGH_ADDR      12'hF94
`define TPG_MODULO_LOW_ADDR      12'hF95
`define TPG_MODE_RESET     8'h00
`define TPG_MODE_WMASK     8'hBB
`define TPG_BIT_MODE       3'h0
`define TPG_BIT_RUN        3'h1
`define TPG_BIT_RELOAD     3'h3
`define TPG_BIT_LEVEL      3'h4
`define TPG_BIT_SOURCE     3'h5
`define TPG_BIT_DRIVE      3'h7
`define TPG_MODULO_LOW_RMASK     8'hFC
`define TPG_CNT_CLEAR      8'h00
`define TPG_MASK_DIV256    8'hFF
`define TPG_MASK_DIV128    8'h7F
`define TPG_MASK_DIV64     8'h3F
`define TPG_MASK_DIV32     8'h1F
`define TPG_MASK_DIV16     8'h0F
`define TPG_BASIC_BITS     10
`define TPG_SECOND_BITS    15
`define TPG_LATCH_BITS     14
`define TPG_FINE_BITS      6
`endif

// ### include/tpg_pkg.sv
// types shared by the timer/pulse generator modules
package tpg_pkg;
    // mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic drive;
        logic unused6;
        logic source;
        logic level;
        logic reload;
        logic zero2;
        logic run;
        logic mode;
    } tpg_mode_t;

    typedef enum logic {
        TPG_PWM   = 1'b0,
        TPG_TIMER = 1'b1
    } tpg_opmode_t;

    // timer run state, gray coded along stop -> arm -> run
    typedef enum logic [1:0] {
        TPG_ST_STOP = 2'b00,
        TPG_ST_ARM  = 2'b01,
        TPG_ST_RUN  = 2'b11
    } tpg_state_t;
endpackage : tpg_pkg

// ### design/tpg_pwm.sv
// 14-bit pwm waveform engine with basic and secondary periods
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tpg_pwm
    import tpg_pkg::*;
#(
    parameter int BASIC_BITS  = `TPG_BASIC_BITS,
    parameter int SECOND_BITS = `TPG_SECOND_BITS
)(
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    input  wire logic                        i_run,
    input  wire logic [`TPG_LATCH_BITS-1:0]  i_latch,
    output logic                             o_pwm_n,
    output logic                             o_basic_start,
    output logic                             o_second_end
);
    localparam int PB = SECOND_BITS - BASIC_BITS;

    logic [SECOND_BITS-1:0] cnt_ff;
    logic [BASIC_BITS-1:0]  phase;
    logic [PB-1:0]          period;
    logic [PB-1:0]          period_rev;
    logic [BASIC_BITS-1:0]  width;
    logic [BASIC_BITS-1:0]  extra;

    assign phase  = cnt_ff[BASIC_BITS-1:0];
    assign period = cnt_ff[SECOND_BITS-1:BASIC_BITS];

    genvar g;
    generate
        for (g = 0; g < PB; g++)
        begin : g_rev
            assign period_rev[g] = period[PB-1-g];
        end
    endgenerate

    // fine bits spread 4-clock steps (bit 0 adds 2 clocks) over the secondary period, so the filter sees
    // the basic period ripple only
    always_comb
    begin
        extra = '0;
        if (period_rev < i_latch[`TPG_FINE_BITS-1:1])
            extra = extra + BASIC_BITS'(4);
        if (i_latch[0] && (period == '0))
            extra = extra + BASIC_BITS'(2);
        width = {i_latch[`TPG_LATCH_BITS-1:`TPG_FINE_BITS], 2'b00} + extra;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cnt_ff <= '0;
        else if (!i_run)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + SECOND_BITS'(1);
    end

    assign o_pwm_n       = !(i_run && (phase < width));  // see RULE_22
    assign o_basic_start = i_run && (phase == '0);
    assign o_second_end  = i_run && (&cnt_ff);           // see RULE_03
endmodule : tpg_pwm

// ### design/tpg_top.sv
// timer/pulse generator: mode register, modulo registers, timer and pwm output pin
`timescale 1ns/10ps
`include "tpg_consts.svh"
// Operation
// RULE_01: timer mode is an 8-bit interval timer on five prescaled clocks, flagging each interval.
// RULE_02: pwm mode drives a 14-bit resolution pwm waveform onto the pulse pin.
// RULE_03: pwm mode raises the interrupt flag once every 2^15 oscillator clocks.
// RULE_04: without pulse output the pin is a one-bit output set by software.
// RULE_05: software disables the block before entering stop standby.
// RULE_06: one 8-bit mode register at F90H, written as a whole byte.
// RULE_07: reload enable at bit 3 is set or cleared alone by bit instructions.
// RULE_08: reload enable 0 blocks modulo transfer to the latch; 1 permits it.
// RULE_09: run enable at bit 1 low stops all operation; high enables it.
// RULE_10: reset clears the mode register: stopped, pwm, no reload, pin undriven.
// RULE_11: mode select bit 0 picks pwm at 0 and interval timer at 1.
// RULE_12: static level bit 4 sets the pin output latch: 0 low, 1 high.
// RULE_13: output source bit 5 routes static level at 0, waveform at 1.
// RULE_14: pin drive bit 7 floats the pin at 0, drives it at 1.
// RULE_15: in timer mode software keeps reload enable at 1.
// RULE_16: timer mode: low modulo picks prescaler, high modulo holds interval count.
// RULE_17: timer counting starts on the run enable rising edge.
// RULE_18: software sets source and drive bits for square wave output.
// RULE_19: software writes only one-hot prescaler codes in low modulo bits 2 to 6.
// RULE_20: software loads high modulo with 1 to 255; interval is prescale times N+1.
// RULE_21: reload fills latch top 8 bits from high modulo, low 6 from low modulo top.
// RULE_22: pwm is active low, width from latch, basic 2^10 and secondary 2^15 periods.
// RULE_23: mode bit 2 stays zero and bit 6 is unused.
// RULE_24: timer match clears the counter, toggles the square wave and sets the flag.
module tpg_top
    import tpg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [11:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_bit_set,
    input  wire logic        i_bit_clr,
    input  wire logic [2:0]  i_bit_pos,
    input  wire logic        i_irq_clr,
    output logic [7:0]       o_rdata,
    output logic             o_irq_flag,
    output logic             o_pin_out,
    output logic             o_pin_oe_n
);
    // ------------------------------------------------------------------
    // register access
    // ------------------------------------------------------------------
    tpg_mode_t   mode_ff;
    logic [7:0]  modulo_high_ff;
    logic [7:0]  modulo_low_ff;
    logic [7:0]  rdata_ff;
    logic        hit_mode;
    logic        bit_reload;

    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction : bit_mask

    assign hit_mode   = (i_addr == `TPG_MODE_ADDR);
    assign bit_reload = hit_mode && (i_bit_pos == `TPG_BIT_RELOAD);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            mode_ff <= tpg_mode_t'(`TPG_MODE_RESET);                       // see RULE_10
        else if (hit_mode && i_wr)
            mode_ff <= tpg_mode_t'(i_wdata & `TPG_MODE_WMASK);             // see RULE_06 RULE_23
        else if (bit_reload && i_bit_set)
            mode_ff <= tpg_mode_t'(mode_ff | bit_mask(`TPG_BIT_RELOAD));   // see RULE_07
        else if (bit_reload && i_bit_clr)
            mode_ff <= tpg_mode_t'(mode_ff & ~bit_mask(`TPG_BIT_RELOAD));  // see RULE_07
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            modulo_high_ff <= 8'h00;
            modulo_low_ff <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == `TPG_MODULO_HIGH_ADDR)
                modulo_high_ff <= i_wdata;
            if (i_addr == `TPG_MODULO_LOW_ADDR)
                modulo_low_ff <= i_wdata;
        end
    end

    // low two bits of the low modulo register have no storage meaning; read as zero
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_ff <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `TPG_MODE_ADDR: rdata_ff <= mode_ff;
                `TPG_MODULO_HIGH_ADDR: rdata_ff <= modulo_high_ff;
                `TPG_MODULO_LOW_ADDR: rdata_ff <= modulo_low_ff & `TPG_MODULO_LOW_RMASK;
                default:        rdata_ff <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // run control and modulo latch
    // ------------------------------------------------------------------
    tpg_state_t                  state_ff;
    logic [`TPG_LATCH_BITS-1:0]  latch_ff;
    logic                        run_q_ff;
    logic                        run_rise;
    logic                        pwm_n;
    logic                        basic_start;
    logic                        second_end;
    logic                        is_timer;

    assign is_timer = (mode_ff.mode == TPG_TIMER);                         // see RULE_11
    assign run_rise = mode_ff.run && !run_q_ff;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            run_q_ff <= 1'b0;
        else
            run_q_ff <= mode_ff.run;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state_ff <= TPG_ST_STOP;
        else
        begin
            case (state_ff)
                TPG_ST_STOP: if (run_rise) state_ff <= TPG_ST_ARM;         // see RULE_17
                TPG_ST_ARM:  state_ff <= mode_ff.run ? TPG_ST_RUN : TPG_ST_STOP;
                TPG_ST_RUN:  if (!mode_ff.run) state_ff <= TPG_ST_STOP;    // see RULE_09
                default:     state_ff <= TPG_ST_STOP;
            endcase
        end
    end

    // a running pwm takes new data only at a basic period start so no torn pulse appears
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            latch_ff <= '0;
        else if (mode_ff.reload && (is_timer || basic_start || !mode_ff.run))  // see RULE_08
            latch_ff <= {modulo_high_ff, modulo_low_ff[7:2]};                           // see RULE_21
    end

    // ------------------------------------------------------------------
    // interval timer
    // ------------------------------------------------------------------
    logic [7:0]  pre_ff;
    logic [7:0]  cnt_ff;
    logic        sq_ff;
    logic [7:0]  pre_mask;
    logic        pre_tick;
    logic        match;
    logic        timer_on;

    function automatic logic [7:0] div_mask(input logic [7:0] sel);
        if (sel[2])
            div_mask = `TPG_MASK_DIV256;
        else if (sel[3])
            div_mask = `TPG_MASK_DIV128;
        else if (sel[4])
            div_mask = `TPG_MASK_DIV64;
        else if (sel[5])
            div_mask = `TPG_MASK_DIV32;
        else
            div_mask = `TPG_MASK_DIV16;
    endfunction : div_mask

    assign timer_on = is_timer && (state_ff == TPG_ST_RUN);
    assign pre_mask = div_mask(modulo_low_ff);                                   // see RULE_16
    assign pre_tick = timer_on && ((pre_ff & pre_mask) == pre_mask);       // see RULE_01
    assign match    = pre_tick && (cnt_ff == latch_ff[`TPG_LATCH_BITS-1:`TPG_FINE_BITS]);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            pre_ff <= `TPG_CNT_CLEAR;
        else if (!timer_on)
            pre_ff <= `TPG_CNT_CLEAR;                                      // see RULE_17
        else
            pre_ff <= pre_ff + 8'h01;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cnt_ff <= `TPG_CNT_CLEAR;
        else if (!timer_on || match)
            cnt_ff <= `TPG_CNT_CLEAR;                                      // see RULE_24
        else if (pre_tick)
            cnt_ff <= cnt_ff + 8'h01;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            sq_ff <= 1'b0;
        else if (match)
            sq_ff <= !sq_ff;                                               // see RULE_24
    end

    // ------------------------------------------------------------------
    // pwm engine
    // ------------------------------------------------------------------
    tpg_pwm u_pwm (
        .i_clk         (i_clk),
        .i_resetn      (i_resetn),
        .i_run         (!is_timer && mode_ff.run),                         // see RULE_09
        .i_latch       (latch_ff),
        .o_pwm_n       (pwm_n),
        .o_basic_start (basic_start),
        .o_second_end  (second_end)
    );

    // ------------------------------------------------------------------
    // interrupt flag and pin
    // ------------------------------------------------------------------
    logic irq_ff;
    logic irq_set;
    logic pin_ff;
    logic oe_n_ff;
    logic wave;

    assign irq_set = match || second_end;                                  // see RULE_03
    assign wave    = is_timer ? sq_ff : pwm_n;                             // see RULE_02

    // a set arriving with a clear wins so no interval is lost
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            irq_ff <= 1'b0;
        else if (irq_set)
            irq_ff <= 1'b1;                                                // see RULE_01
        else if (i_irq_clr)
            irq_ff <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_ff  <= 1'b0;
            oe_n_ff <= 1'b1;                                               // see RULE_10
        end
        else
        begin
            pin_ff  <= mode_ff.source ? wave : mode_ff.level;              // see RULE_04 RULE_12 RULE_13
            oe_n_ff <= !mode_ff.drive;                                     // see RULE_14
        end
    end

    assign o_rdata    = rdata_ff;
    assign o_irq_flag = irq_ff;
    assign o_pin_out  = pin_ff;
    assign o_pin_oe_n = oe_n_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_match_seen;
        match ##1 (cnt_ff == `TPG_CNT_CLEAR);
    endsequence

    AST_MODE_WRITE: assert property (hit_mode && i_wr
        |=> mode_ff == ($past(i_wdata) & `TPG_MODE_WMASK)) // see RULE_06
        else $error("mode write not stored");
    AST_BIT_SET: assert property (bit_reload && i_bit_set && !i_wr
        |=> mode_ff.reload && $stable({mode_ff.drive, mode_ff.source, mode_ff.run})) // see RULE_07
        else $error("bit set disturbed register");
    AST_ZERO_BITS: assert property (!mode_ff.zero2 && !mode_ff.unused6) // see RULE_23
        else $error("fixed bits not zero");
    AST_NO_RELOAD: assert property (!mode_ff.reload |=> $stable(latch_ff)) // see RULE_08
        else $error("latch moved with reload off");
    AST_MATCH: assert property (s_match_seen |-> sq_ff != $past(sq_ff) && irq_ff) // see RULE_24
        else $error("match effects missing");
    AST_STOPPED: assert property (!mode_ff.run |-> ##2 !timer_on && !second_end) // see RULE_09
        else $error("block runs while disabled");
    AST_PIN_DRIVE: assert property ($changed(mode_ff.drive)
        |=> o_pin_oe_n == !$past(mode_ff.drive)) // see RULE_14
        else $error("pin drive not applied");
    AST_STATIC: assert property (!mode_ff.source ##1 !mode_ff.source
        |-> o_pin_out == $past(mode_ff.level)) // see RULE_12
        else $error("static level not on pin");
    AST_PWM_IRQ: assert property (second_end |=> irq_ff ##1 !second_end [*8]) // see RULE_03
        else $error("pwm interval flag wrong");
    AST_START: assert property (is_timer && run_rise
        |-> ##2 timer_on && cnt_ff == `TPG_CNT_CLEAR) // see RULE_17
        else $error("timer did not start cleared");

    // the flag must survive a clear that lands in the same cycle as an interval end
    AST_IRQ_SET: assert property (irq_set |=> irq_ff) // see RULE_01
        else $error("interval flag not raised");
    AST_LATCH_TIMER: assert property (mode_ff.reload && is_timer
        |=> latch_ff[`TPG_LATCH_BITS-1:`TPG_FINE_BITS] == $past(modulo_high_ff)) // see RULE_21
        else $error("latch does not follow high modulo");
endmodule : tpg_top

// ### sim/tpg_lpf_load.sv
// load model on the pulse pin: pull-down resistor and low-time integrator
`timescale 1ns/10ps
module tpg_lpf_load (
    input  wire logic        i_clk,
    input  wire logic        i_pin_out,
    input  wire logic        i_pin_oe_n,
    input  wire logic        i_clr,
    output logic             o_level,
    output logic [15:0]      o_low_cnt
);
    // ------------------------------------------------------------
    // pin level
    // ------------------------------------------------------------
    // the pull-down gives a floating pin a known level, not the last driven one
    assign o_level = i_pin_oe_n ? 1'b0 : i_pin_out;

    // ------------------------------------------------------------
    // low time integrator
    // ------------------------------------------------------------
    // counting low clocks stands in for the filter's average voltage
    always_ff @(posedge i_clk)
    begin
        if (i_clr)
            o_low_cnt <= 16'h0000;
        else if (o_level == 1'b0)
            o_low_cnt <= o_low_cnt + 16'h0001;
    end
endmodule : tpg_lpf_load

// ### sim/tb_top.sv
// self-checking testbench of the timer/pulse generator
`timescale 1ns/10ps
`include "tpg_consts.svh"
module tb_top;
    logic        clk;
    logic        resetn;
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
    logic        bset;
    logic        bclr;
    logic [2:0]  bpos;
    logic        irq_clr;
    logic [7:0]  rdata;
    logic        irq;
    logic        pin_out;
    logic        pin_oe_n;
    logic        level;
    logic [15:0] low_cnt;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc;
    logic        p0;
    int          divs[5]  = '{256, 128, 64, 32, 16};
    logic [7:0]  codes[5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    logic [7:0]  ns[5]    = '{8'h03, 8'h01, 8'h02, 8'h01, 8'hFF};

    always #20 clk = ~clk;

    tpg_top dut (
        .i_clk      (clk),
        .i_resetn   (resetn),
        .i_addr     (addr),
        .i_wr       (wr),
        .i_rd       (rd),
        .i_wdata    (wdata),
        .i_bit_set  (bset),
        .i_bit_clr  (bclr),
        .i_bit_pos  (bpos),
        .i_irq_clr  (irq_clr),
        .o_rdata    (rdata),
        .o_irq_flag (irq),
        .o_pin_out  (pin_out),
        .o_pin_oe_n (pin_oe_n)
    );

    tpg_lpf_load load (
        .i_clk      (clk),
        .i_pin_out  (pin_out),
        .i_pin_oe_n (pin_oe_n),
        .i_clr      (irq_clr),
        .o_level    (level),
        .o_low_cnt  (low_cnt)
    );

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(nm, rdata, exp);
    endtask : reg_rd

    task automatic bit_op(input logic set, input logic [2:0] pos);
        @(negedge clk);
        addr = `TPG_MODE_ADDR;
        bpos = pos;
        bset = set;
        bclr = !set;
        @(negedge clk);
        bset = 1'b0;
        bclr = 1'b0;
    endtask : bit_op

    // clocks from the previous flag (or from the call) until the next flag
    task automatic gap(input logic clr, input int lim, output int c);
        c = 0;
        if (clr)
        begin
            @(negedge clk);
            irq_clr = 1'b1;
            @(negedge clk);
            irq_clr = 1'b0;
            c = 2;
        end
        while (irq !== 1'b1 && c < lim)
        begin
            @(negedge clk);
            c++;
        end
    endtask : gap

    task automatic close_out();
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        addr = 12'h000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        bset = 1'b0;
        bclr = 1'b0;
        bpos = 3'h0;
        irq_clr = 1'b0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        chk("oe_n_rst", pin_oe_n, 1'b1);
        chk("irq_rst", irq, 1'b0);
        reg_rd(`TPG_MODE_ADDR, `TPG_MODE_RESET, "mode_rst");
        reg_wr(`TPG_MODE_ADDR, 8'hCC);
        reg_rd(`TPG_MODE_ADDR, 8'h88, "mode_fixed");
        bit_op(1'b0, 3'h3);
        reg_rd(`TPG_MODE_ADDR, 8'h80, "bit_clr");
        bit_op(1'b1, 3'h1);
        reg_rd(`TPG_MODE_ADDR, 8'h80, "bit_other");
        bit_op(1'b1, 3'h3);
        reg_rd(`TPG_MODE_ADDR, 8'h88, "bit_set");
        reg_rd(12'hF91, 8'h00, "unmapped");
        reg_wr(`TPG_MODULO_LOW_ADDR, 8'hFF);
        reg_rd(`TPG_MODULO_LOW_ADDR, 8'hFC, "modulo_low");
        // static output through the output latch
        reg_wr(`TPG_MODE_ADDR, 8'h90);
        repeat (2) @(negedge clk);
        chk("static_hi", level, 1'b1);
        chk("driven", pin_oe_n, 1'b0);
        reg_wr(`TPG_MODE_ADDR, 8'h80);
        repeat (2) @(negedge clk);
        chk("static_lo", level, 1'b0);
        reg_wr(`TPG_MODE_ADDR, 8'h10);
        repeat (2) @(negedge clk);
        chk("float", pin_oe_n, 1'b1);
        // timer: nothing counts while run is low, then start on its rising edge
        reg_wr(`TPG_MODULO_LOW_ADDR, 8'h40);
        reg_wr(`TPG_MODULO_HIGH_ADDR, 8'h01);
        reg_wr(`TPG_MODE_ADDR, 8'hA9);
        gap(1'b1, 600, cyc);
        chk("stopped", irq, 1'b0);
        reg_wr(`TPG_MODE_ADDR, 8'hAB);
        gap(1'b0, 100, cyc);
        chk("start", (cyc >= 31 && cyc <= 36), 1'b1);
        for (int k = 0; k < 5; k++)
        begin
            // restarting keeps a shorter count from wrapping past a new match value
            reg_wr(`TPG_MODE_ADDR, 8'hA9);
            reg_wr(`TPG_MODULO_LOW_ADDR, codes[k]);
            reg_wr(`TPG_MODULO_HIGH_ADDR, ns[k]);
            reg_wr(`TPG_MODE_ADDR, 8'hAB);
            gap(1'b1, 9000, cyc);
            p0 = level;
            gap(1'b1, 9000, cyc);
            chk("interval", cyc, divs[k] * (int'(ns[k]) + 1));
            chk("square", level, !p0);
        end
        // pwm: latch loads while stopped, then reload is blocked during the run
        reg_wr(`TPG_MODE_ADDR, 8'hA8);
        reg_wr(`TPG_MODULO_HIGH_ADDR, 8'h40);
        reg_wr(`TPG_MODULO_LOW_ADDR, 8'hFC);
        repeat (4) @(negedge clk);
        chk("pwm_idle", level, 1'b1);
        reg_wr(`TPG_MODE_ADDR, 8'hAA);
        bit_op(1'b0, 3'h3);
        reg_wr(`TPG_MODULO_HIGH_ADDR, 8'h10);
        gap(1'b1, 40000, cyc);
        gap(1'b1, 40000, cyc);
        chk("pwm_flag", cyc, 32768);
        repeat (2) @(negedge clk);
        chk("low_time", low_cnt, 16'h207E);
        reg_wr(`TPG_MODE_ADDR, 8'h00);
        repeat (2) @(negedge clk);
        chk("off", pin_oe_n, 1'b1);
        close_out();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule : tb_top
